/* File: core/relay_map_pkg.sv */
// Package for the trip relay function mapper: register map, fields, encodings.
// Assumes a 32-bit AXI4-Lite register bus and a single 20 MHz clock.
package relay_map_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ONBOARD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MOD_BASE = 8'h10;

    // Control fields
    localparam int CTRL_PULSE_EN = 0;
    localparam int CTRL_AUTO_RESET = 1;
    localparam int CTRL_ALARM_LOG = 2;
    localparam int CTRL_MOD_EN_LSB = 4;

    // On-board group enables: relay A groups 1,2; B and C groups 1,3
    localparam int GRP_A1 = 0;
    localparam int GRP_A2 = 1;
    localparam int GRP_B1 = 4;
    localparam int GRP_B3 = 6;
    localparam int GRP_C1 = 8;
    localparam int GRP_C3 = 10;
    localparam logic [31:0] ONBOARD_MASK = 32'h0000_0553;

    // ----------------------------------------------------------------
    // Counts and sizes
    // ----------------------------------------------------------------
    localparam int NUM_MODULES = 4;
    localparam int RELAYS_PER_MODULE = 4;
    localparam int NUM_ACC = NUM_MODULES * RELAYS_PER_MODULE;
    localparam int AUTO_RESET_MS = 5000;
    localparam int CLOCK_KHZ = 20000;
    localparam int AUTO_RESET_CYCLES = AUTO_RESET_MS * CLOCK_KHZ;

    // ----------------------------------------------------------------
    // Accessory relay function codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FN_OFF = 4'h0,
        FN_POSITION = 4'h1,
        FN_ALARM_MIRROR = 4'h2,
        FN_BELL = 4'h3,
        FN_LINK_OK = 4'h4,
        FN_HEALTH = 4'h5,
        FN_LONG_DELAY = 4'h6,
        FN_SHORT_DELAY = 4'h7,
        FN_IMMEDIATE = 4'h8,
        FN_GROUND = 4'h9,
        FN_HIGH_LOAD = 4'hA,
        FN_GROUND_WARN = 4'hB
    } relay_function_select_t;

    // Protection conditions from the trip core
    typedef struct packed {
        logic long_delay;
        logic short_delay;
        logic immediate;
        logic ground;
        logic other_trip;
    } trip_cond_t;

    typedef struct packed {
        logic high_load;
        logic ground_fault;
        logic [2:0] group;
    } alarm_cond_t;

    typedef struct packed {
        logic green_led;
        logic red_led;
    } led_t;

endpackage

/* File: core/trip_relay_function_mapper.sv */
// Trip relay function mapper: on-board relays A/B/C, 16 accessory relays,
// link indicators and event log gating, configured over AXI4-Lite.
// Assumes trip/alarm inputs are synchronous to aclk; pushbutton, breaker
// state and supply-low are asynchronous pins and are synchronised here.
//
// How it works
// [R01] A takes groups 1,2; B and C take groups 1,3; pulse only on A
// [R02] Pulse enable on A ignores all groups and drives only the pulse
// [R03] Several functions may drive one relay, pulse never combines
// [R04] Enabled marker per on-board relay when any group is enabled
// [R05] Accessory modules are addressed 1 to 4 only
// [R06] Four relays per module, each with its own function code
// [R07] Function codes cover position, alarm, bell, link, health, trips, warns, off
// [R08] Bell relay drives on any protection trip
// [R09] Trip-type relays drive only on their own trip type
// [R10] Warning relays follow high load or ground fault warning
// [R11] Alarm mirror follows relay A alarm groups, never the pulse
// [R12] Health relay energised while healthy, drops on fault or low supply
// [R13] Link relay picked up while its module answers, drops otherwise
// [R14] Device masters the accessory link, green lamp while sending
// [R15] Red lamp while sending on the network link
// [R16] Alarms reach the event log only when alarm logging is enabled
// [R17] Position relay tracks breaker open or closed state
// [R18] B and C share manual or auto reset; auto clears within five seconds
// [R19] Off relays stay de-energised
// [R20] Trip outputs latch until reset clears them
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module trip_relay_function_mapper
    import relay_map_pkg::*;
#(
    parameter int AUTO_RESET_COUNT = AUTO_RESET_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire trip_cond_t trip_in,
    input wire alarm_cond_t alarm_in,
    input wire logic pulse_in,
    input wire logic unit_fault,
    input wire logic supply_low_pin,
    input wire logic breaker_closed_pin,
    input wire logic reset_button_pin,
    input wire logic [NUM_MODULES-1:0] module_comm_ok,
    input wire logic acc_tx_active,
    input wire logic net_tx_active,
    input wire logic trip_event,
    input wire logic alarm_event,
    output logic relay_a,
    output logic relay_b,
    output logic relay_c,
    output logic [2:0] relay_enabled_marker,
    output logic [NUM_ACC-1:0] acc_relay,
    output led_t leds,
    output logic log_write
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [31:0] ctrl;
        logic [31:0] onboard;
        logic [NUM_ACC*4-1:0] func;
        trip_cond_t trip_latch;
        logic bc_latch;
        logic [31:0] auto_cnt;
        logic [2:0] s_low;
        logic [2:0] s_closed;
        logic [2:0] s_button;
        logic supply_low;
        logic closed;
        logic button;
        logic button_q;
        logic ra;
        logic rb;
        logic rc;
        logic [2:0] marker;
        logic [NUM_ACC-1:0] acc;
        led_t leds;
        logic log_wr;
    } state_t;

    state_t state_r;
    state_t state_nxt;
    logic any_trip;
    logic a_alarm;
    logic clear_req;
    logic [NUM_ACC-1:0] acc_drive;
    logic [7:0] rd_addr;
    logic [4:0] mod_idx;

    // ----------------------------------------------------------------
    // Accessory relay drive, one per relay
    // ----------------------------------------------------------------
    assign any_trip = |state_r.trip_latch;
    // Relay A alarm assignment: alarm groups 1 and 2 as enabled
    assign a_alarm = (alarm_in.group[0] & state_r.onboard[GRP_A1])
        | (alarm_in.group[1] & state_r.onboard[GRP_A2]);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ACC; gi++)
        begin : g_acc
            relay_function_select_t fsel;
            logic mod_on;
            logic drv;
            assign fsel = relay_function_select_t'(state_r.func[gi*4 +: 4]);
            // One process per bit would give the vector many drivers; each drives its own net
            assign acc_drive[gi] = drv;
            // [R05] Module enable
            assign mod_on = state_r.ctrl[CTRL_MOD_EN_LSB + gi / RELAYS_PER_MODULE];
            always_comb
            begin
                // [R07] Function decode
                case (fsel)
                    // [R17] Follow breaker
                    FN_POSITION: drv = state_r.closed;
                    // [R11] Mirror relay A alarms
                    FN_ALARM_MIRROR: drv = a_alarm;
                    // [R08] Any trip
                    FN_BELL: drv = any_trip;
                    // [R13] Module link integrity
                    FN_LINK_OK: drv = module_comm_ok[gi / RELAYS_PER_MODULE];
                    // [R12] Healthy unit
                    FN_HEALTH: drv = ~unit_fault & ~state_r.supply_low;
                    // [R09] Trip-specific
                    FN_LONG_DELAY: drv = state_r.trip_latch.long_delay;
                    FN_SHORT_DELAY: drv = state_r.trip_latch.short_delay;
                    FN_IMMEDIATE: drv = state_r.trip_latch.immediate;
                    FN_GROUND: drv = state_r.trip_latch.ground;
                    // [R10] Warnings
                    FN_HIGH_LOAD: drv = alarm_in.high_load;
                    FN_GROUND_WARN: drv = alarm_in.ground_fault;
                    // [R19] Off stays dropped
                    default: drv = 1'b0;
                endcase
                if (!mod_on)
                begin
                    drv = 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        rd_addr = 8'h00;
        mod_idx = 5'h00;
        clear_req = 1'b0;

        // Pins pass three stages; a change counts when stages two and three agree
        state_nxt.s_low = {state_r.s_low[1:0], supply_low_pin};
        state_nxt.s_closed = {state_r.s_closed[1:0], breaker_closed_pin};
        state_nxt.s_button = {state_r.s_button[1:0], reset_button_pin};
        if (state_r.s_low[2] == state_r.s_low[1])
        begin
            state_nxt.supply_low = state_r.s_low[2];
        end
        if (state_r.s_closed[2] == state_r.s_closed[1])
        begin
            state_nxt.closed = state_r.s_closed[2];
        end
        if (state_r.s_button[2] == state_r.s_button[1])
        begin
            state_nxt.button = state_r.s_button[2];
        end
        state_nxt.button_q = state_r.button;

        // AXI write: address and data taken in either order
        if (s_axi_awvalid && state_r.awready)
        begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
            state_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && state_r.wready)
        begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = s_axi_wdata;
            state_nxt.w_strb = s_axi_wstrb;
            state_nxt.wready = 1'b0;
        end
        if (state_r.aw_held && state_r.w_held && !state_r.bvalid)
        begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = 2'h0;
            if (state_r.aw_addr[7:2] == OFF_CTRL[7:2])
            begin
                state_nxt.ctrl = state_r.w_data & 32'h0000_00F7;
            end
            else if (state_r.aw_addr[7:2] == OFF_ONBOARD[7:2])
            begin
                // [R01] Only legal groups are stored
                state_nxt.onboard = state_r.w_data & ONBOARD_MASK;
            end
            else if (state_r.aw_addr[7:4] == OFF_MOD_BASE[7:4])
            begin
                // [R06] One code per relay, any mix allowed
                mod_idx = {3'h0, state_r.aw_addr[3:2]};
                state_nxt.func[mod_idx*16 +: 16] = state_r.w_data[15:0];
            end
            else
            begin
                state_nxt.bresp = 2'h2;
            end
        end
        if (state_r.bvalid && s_axi_bready)
        begin
            state_nxt.bvalid = 1'b0;
            state_nxt.awready = 1'b1;
            state_nxt.wready = 1'b1;
        end

        // AXI read
        if (s_axi_arvalid && state_r.arready)
        begin
            state_nxt.arready = 1'b0;
            state_nxt.rvalid = 1'b1;
            state_nxt.rresp = 2'h0;
            rd_addr = s_axi_araddr;
            if (rd_addr[7:2] == OFF_CTRL[7:2])
            begin
                state_nxt.rdata = state_r.ctrl;
            end
            else if (rd_addr[7:2] == OFF_ONBOARD[7:2])
            begin
                state_nxt.rdata = state_r.onboard;
            end
            else if (rd_addr[7:2] == OFF_STATUS[7:2])
            begin
                state_nxt.rdata = {state_r.acc, 5'h00, state_r.marker,
                    state_r.rc, state_r.rb, state_r.ra, state_r.trip_latch};
            end
            else if (rd_addr[7:4] == OFF_MOD_BASE[7:4])
            begin
                mod_idx = {3'h0, rd_addr[3:2]};
                state_nxt.rdata = {16'h0000, state_r.func[mod_idx*16 +: 16]};
            end
            else
            begin
                state_nxt.rdata = 32'h0000_0000;
                state_nxt.rresp = 2'h2;
            end
        end
        if (state_r.rvalid && s_axi_rready)
        begin
            state_nxt.rvalid = 1'b0;
            state_nxt.arready = 1'b1;
        end

        // [R18] Manual clear on button press, auto clear after the delay
        if (state_r.button && !state_r.button_q)
        begin
            clear_req = 1'b1;
        end
        if (state_r.ctrl[CTRL_AUTO_RESET] && state_r.bc_latch)
        begin
            if (state_r.auto_cnt >= AUTO_RESET_COUNT - 1)
            begin
                clear_req = 1'b1;
            end
            else
            begin
                state_nxt.auto_cnt = state_r.auto_cnt + 32'h0000_0001;
            end
        end
        // [R20] Trips latch; a new trip wins over the clear
        if (clear_req)
        begin
            state_nxt.trip_latch = trip_in;
            state_nxt.bc_latch = |trip_in;
            state_nxt.auto_cnt = 32'h0000_0000;
        end
        else
        begin
            state_nxt.trip_latch = state_r.trip_latch | trip_in;
            state_nxt.bc_latch = state_r.bc_latch | (|trip_in);
        end

        // [R02] Pulse dedicates relay A; [R03] never mixed with groups
        if (state_r.ctrl[CTRL_PULSE_EN])
        begin
            state_nxt.ra = pulse_in;
        end
        else
        begin
            state_nxt.ra = a_alarm;
        end
        // B and C: group 1 trip latch, group 3 alarm group 3
        state_nxt.rb = (state_r.onboard[GRP_B1] & state_r.bc_latch)
            | (state_r.onboard[GRP_B3] & alarm_in.group[2]);
        state_nxt.rc = (state_r.onboard[GRP_C1] & state_r.bc_latch)
            | (state_r.onboard[GRP_C3] & alarm_in.group[2]);
        // [R04] Enabled markers
        state_nxt.marker[0] = state_r.ctrl[CTRL_PULSE_EN]
            | state_r.onboard[GRP_A1] | state_r.onboard[GRP_A2];
        state_nxt.marker[1] = state_r.onboard[GRP_B1] | state_r.onboard[GRP_B3];
        state_nxt.marker[2] = state_r.onboard[GRP_C1] | state_r.onboard[GRP_C3];
        state_nxt.acc = acc_drive;

        // [R14] Green lamp on accessory transmit
        state_nxt.leds.green_led = acc_tx_active;
        // [R15] Red lamp on network transmit
        state_nxt.leds.red_led = net_tx_active;
        // [R16] Alarm events logged only when enabled
        state_nxt.log_wr = trip_event | (alarm_event & state_r.ctrl[CTRL_ALARM_LOG]);
    end

    // ----------------------------------------------------------------
    // Registers; ready signals come up one cycle after reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            if (!state_r.awready && !state_r.aw_held && !state_r.bvalid && !state_r.w_held
                && !state_r.wready)
            begin
                state_r.awready <= 1'b1;
                state_r.wready <= 1'b1;
            end
            if (!state_r.arready && !state_r.rvalid)
            begin
                state_r.arready <= 1'b1;
            end
        end
    end

    assign s_axi_awready = state_r.awready;
    assign s_axi_wready = state_r.wready;
    assign s_axi_bresp = state_r.bresp;
    assign s_axi_bvalid = state_r.bvalid;
    assign s_axi_arready = state_r.arready;
    assign s_axi_rdata = state_r.rdata;
    assign s_axi_rresp = state_r.rresp;
    assign s_axi_rvalid = state_r.rvalid;
    assign relay_a = state_r.ra;
    assign relay_b = state_r.rb;
    assign relay_c = state_r.rc;
    assign relay_enabled_marker = state_r.marker;
    assign acc_relay = state_r.acc;
    assign leds = state_r.leds;
    assign log_write = state_r.log_wr;

endmodule // trip_relay_function_mapper

/* File: dv/relay_map_monitor.sv */
// Checker for the trip relay function mapper, bound to its top module.
// Assumes one aclk domain and a synchronous active-low reset.
`timescale 1ns/1ps
module relay_map_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic acc_tx_active,
    input wire logic net_tx_active,
    input wire logic trip_event,
    input wire logic alarm_event,
    input wire logic relay_b,
    input wire logic [relay_map_pkg::NUM_ACC-1:0] acc_relay,
    input wire relay_map_pkg::led_t leds,
    input wire logic log_write
);
    import relay_map_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Both halves of a write taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    chk_red_lamp: assert property (1'b1 |=> leds.red_led == $past(net_tx_active))
        else $error("red lamp does not follow network transmit");
    chk_green_lamp: assert property (1'b1 |=> leds.green_led == $past(acc_tx_active))
        else $error("green lamp does not follow accessory transmit");
    chk_trip_logged: assert property (trip_event |=> log_write)
        else $error("trip event not written to log");
    chk_quiet_log: assert property (!trip_event && !alarm_event |=> !log_write)
        else $error("log write without an event");
    chk_reset_clear: assert property ($rose(aresetn) |-> acc_relay == '0 && !relay_b)
        else $error("relays not clear after reset");
    chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) // bus answer
        else $error("write response late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // bus hold
        else $error("write response dropped early");
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready) // bus answer
        else $error("read response late");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) // bus hold
        else $error("read data changed while waiting");
endmodule // relay_map_monitor

bind trip_relay_function_mapper relay_map_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .acc_tx_active, .net_tx_active, .trip_event, .alarm_event, .relay_b, .acc_relay,
    .leds, .log_write);

/* File: dv/acc_module_model.sv */
// Stand-in for the four accessory relay modules on the accessory link.
// Assumes the bench says which modules go silent; recovery is slow.
`timescale 1ns/1ps
module acc_module_model
#(
    parameter int LAG = 3
)
(
    input wire logic aclk,
    input wire logic [3:0] silent,
    output logic [3:0] module_comm_ok
);
    int cnt_r [4];
    // addresses 1 to 4; drop at once, answer again only after LAG cycles
    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (silent[i])
                cnt_r[i] <= 0;
            else if (cnt_r[i] < LAG)
                cnt_r[i] <= cnt_r[i] + 1;
        end
    end
    // Link good flag per address
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            module_comm_ok[i] = (cnt_r[i] == LAG);
    end
endmodule // acc_module_model

/* File: dv/tb_top.sv */
// Self-checking bench for the trip relay function mapper.
// Assumes a 20 MHz aclk and a short auto-reset count of 20 cycles.
`timescale 1ns/1ps
module tb_top;
    import relay_map_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, pulse_in = 1'b0, unit_fault = 1'b0;
    logic supply_low_pin = 1'b0, breaker_closed_pin = 1'b1, reset_button_pin = 1'b0;
    logic acc_tx_active = 1'b0, net_tx_active = 1'b0, trip_event = 1'b0, alarm_event = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] silent = 4'h0, module_comm_ok;
    trip_cond_t trip_in = '0;
    alarm_cond_t alarm_in = '0;
    logic awready, wready, bvalid, arready, rvalid, relay_a, relay_b, relay_c, log_write;
    logic [1:0] bresp, rresp;
    logic [2:0] marker;
    logic [NUM_ACC-1:0] acc_relay;
    led_t leds;
    int num_errors = 0, checks = 0;
    logic [15:0] xp [5] = '{16'h0003, 16'h0401, 16'h0005, 16'h0801, 16'h0001};

    trip_relay_function_mapper #(.AUTO_RESET_COUNT(20)) dut_u (.aclk, .aresetn,
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .trip_in, .alarm_in, .pulse_in,
        .unit_fault, .supply_low_pin, .breaker_closed_pin, .reset_button_pin,
        .module_comm_ok, .acc_tx_active, .net_tx_active, .trip_event, .alarm_event,
        .relay_a, .relay_b, .relay_c, .relay_enabled_marker(marker), .acc_relay, .leds,
        .log_write);
    acc_module_model #(.LAG(3)) part_u (.aclk, .silent, .module_comm_ok);

    // Clock: 50 ns period
    initial
    begin
        forever #25 aclk = ~aclk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready)
            begin
                bready <= 1'b0;
                chk(bresp, er);
                return;
            end
        end
        chk(1, 0);
        wrap_up();
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready)
            begin
                rready <= 1'b0;
                chk(rdata, ed);
                chk(rresp, er);
                return;
            end
        end
        chk(1, 0);
        wrap_up();
    endtask
    // Bounded wait for the relay vector, then compare at a quiet point
    task automatic wait_acc(input logic [15:0] e, input int lim);
        for (int n = 0; n < lim && acc_relay !== e; n++)
            @(negedge aclk);
        chk(acc_relay, e);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs();
        axi_wr(OFF_ONBOARD, 32'hFFFF_FFFF, 2'h0);
        axi_rd(OFF_ONBOARD, ONBOARD_MASK, 2'h0);
        axi_wr(8'h20, 32'h0000_0001, 2'h2);
        axi_rd(8'h20, 32'h0, 2'h2);
        axi_wr(OFF_CTRL, 32'h0000_0074, 2'h0);
        axi_rd(OFF_CTRL, 32'h0000_0074, 2'h0);
        chk(marker, 3'h7);
        // every function code across three modules, module 4 disabled
        axi_wr(OFF_MOD_BASE, 32'h0000_0863, 2'h0);
        axi_wr(OFF_MOD_BASE + 8'h04, 32'h0000_45BA, 2'h0);
        axi_wr(OFF_MOD_BASE + 8'h08, 32'h0000_9721, 2'h0);
        axi_wr(OFF_MOD_BASE + 8'h0C, 32'h0000_5555, 2'h0);
        axi_rd(OFF_MOD_BASE + 8'h04, 32'h0000_45BA, 2'h0);
        $display("test_regs done");
    endtask
    task automatic test_levels();
        wait_acc(16'h01C0, 12);
        alarm_in <= 5'b11001;
        wait_acc(16'h03F0, 12);
        chk(relay_a, 1'b1);
        alarm_in <= '0;
        unit_fault <= 1'b1;
        wait_acc(16'h0180, 12);
        unit_fault <= 1'b0;
        wait_acc(16'h01C0, 12);
        supply_low_pin <= 1'b1;
        wait_acc(16'h0180, 12);
        supply_low_pin <= 1'b0;
        silent <= 4'h2;
        wait_acc(16'h0140, 12);
        silent <= 4'h0;
        breaker_closed_pin <= 1'b0;
        wait_acc(16'h00C0, 12);
        breaker_closed_pin <= 1'b1;
        wait_acc(16'h01C0, 12);
        $display("test_levels done");
    endtask
    // manual clear by pushbutton after each trip kind
    task automatic test_trips();
        for (int i = 0; i < 5; i++)
        begin
            @(posedge aclk);
            trip_in <= 5'h10 >> i;
            @(posedge aclk);
            trip_in <= '0;
            wait_acc(16'h01C0 | xp[i], 12);
            repeat (30) @(negedge aclk);
            chk(acc_relay, 16'h01C0 | xp[i]);
            chk({relay_b, relay_c}, 2'h3);
            reset_button_pin <= 1'b1;
            repeat (8) @(posedge aclk);
            reset_button_pin <= 1'b0;
            wait_acc(16'h01C0, 12);
        end
        $display("test_trips done");
    endtask
    task automatic test_auto();
        axi_wr(OFF_CTRL, 32'h0000_0076, 2'h0);
        trip_in <= 5'h04;
        @(posedge aclk);
        trip_in <= '0;
        wait_acc(16'h01C5, 12);
        wait_acc(16'h01C0, 40);
        chk({relay_b, relay_c}, 2'h0);
        axi_rd(OFF_STATUS, 32'h01C0_0700, 2'h0);
        $display("test_auto done");
    endtask
    task automatic test_log_lamps(input logic en);
        axi_wr(OFF_CTRL, {29'h0000_000E, en, 2'b00}, 2'h0);
        alarm_event <= 1'b1;
        acc_tx_active <= 1'b1;
        net_tx_active <= 1'b1;
        @(posedge aclk);
        alarm_event <= 1'b0;
        @(negedge aclk);
        chk(log_write, en);
        chk(leds, 2'b11);
        acc_tx_active <= 1'b0;
        net_tx_active <= 1'b0;
        trip_event <= 1'b1;
        @(posedge aclk);
        trip_event <= 1'b0;
        @(negedge aclk);
        chk(log_write, 1'b1);
        chk(leds, 2'b00);
        $display("test_log_lamps done");
    endtask
    // pulse takes relay A alone, groups ignored
    task automatic test_pulse();
        axi_wr(OFF_CTRL, 32'h0000_0071, 2'h0);
        alarm_in <= 5'b00011;
        repeat (4) @(negedge aclk);
        chk(relay_a, 1'b0);
        pulse_in <= 1'b1;
        repeat (4) @(negedge aclk);
        chk(relay_a, 1'b1);
        pulse_in <= 1'b0;
        alarm_in <= '0;
        $display("test_pulse done");
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_regs();
        test_levels();
        test_trips();
        test_auto();
        test_log_lamps(1'b1);
        test_log_lamps(1'b0);
        test_pulse();
        wrap_up();
    end
endmodule // tb_top
